// File: pkg/cuw_pkg.sv
// package: register map, field layout and types of the clock unit mask and write guard
package cuw_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_PLL_SETUP     = 8'h00;
  localparam logic [7:0] OFF_DIVIDER_SETUP = 8'h04;
  localparam logic [7:0] OFF_CLOCK_FLAGS   = 8'h08;
  localparam logic [7:0] OFF_CLOCK_MODE    = 8'h0c;
  localparam logic [7:0] OFF_IRQ_MASKING   = 8'h10;
  localparam logic [7:0] OFF_WRITE_GUARD   = 8'h14;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int BIT_LOCK_GAIN   = 15;
  localparam int BIT_LOCK_LOST   = 14;
  localparam int BIT_STOP_ENABLE = 0;
  localparam int BIT_UNLOCK      = 0;

  // ------------------------------------------------------------
  // writable masks and reset values
  // ------------------------------------------------------------
  localparam logic [15:0] MASK_PLL_SETUP   = 16'h43ff;
  localparam logic [15:0] MASK_DIVIDER     = 16'h001f;
  localparam logic [15:0] MASK_CLOCK_MODE  = 16'h000f;
  localparam logic [15:0] MASK_IRQ_MASKING = 16'hc001;
  localparam logic [15:0] MASK_WRITE_GUARD = 16'h0001;
  localparam logic [15:0] RST_PLL_SETUP    = 16'h0000;
  localparam logic [15:0] RST_DIVIDER      = 16'h0000;
  localparam logic [15:0] RST_CLOCK_MODE   = 16'h0000;
  localparam logic [15:0] RST_IRQ_MASKING  = 16'h0000;
  localparam logic [15:0] RST_WRITE_GUARD  = 16'h0000;

  // ------------------------------------------------------------
  // carrier for the protected clock settings
  // ------------------------------------------------------------
  typedef struct packed {
    logic [15:0] pll_setup;
    logic [15:0] divider_setup;
    logic [15:0] clock_mode_control;
  } cuw_clk_cfg_t;

  // ------------------------------------------------------------
  // apb access decode states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    CUW_IDLE   = 2'b00,
    CUW_ACCESS = 2'b01
  } cuw_state_t;

endpackage

// File: design/cuw_sync.sv
// module: two flip-flop synchroniser for one level
`timescale 1ns/100ps
`default_nettype none

module cuw_sync
  import cuw_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  // level in and out
  input  wire logic async_in,
  output logic      sync_out
);

  logic stage1_ff;
  logic stage2_ff;
  logic nxt_stage1;
  logic nxt_stage2;

  always_comb
  begin
    nxt_stage1 = stage1_ff;
    nxt_stage2 = stage2_ff;
    if (clk_en)
    begin
      nxt_stage1 = async_in;
      nxt_stage2 = stage1_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage1_ff <= 1'b0;
      stage2_ff <= 1'b0;
    end
    else
    begin
      stage1_ff <= nxt_stage1;
      stage2_ff <= nxt_stage2;
    end
  end

  assign sync_out = stage2_ff;

endmodule

`default_nettype wire

// File: design/cuw_top.sv
// module: clock unit interrupt mask, lock flags and write guard behind apb
//
// Local design decision: the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module cuw_top
  import cuw_pkg::*;
(
  // clock, reset and enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // pll lock pin
  input  wire logic        pll_lock,
  // read-only clock status bits 6:0
  input  wire logic [6:0]  clk_status,
  // outputs to the clock unit
  output cuw_clk_cfg_t     clk_cfg,
  output logic             stop_enable,
  output logic             unit_irq
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic is_protected(input logic [7:0] a);
    is_protected = (a == OFF_PLL_SETUP) || (a == OFF_DIVIDER_SETUP)
                   || (a == OFF_CLOCK_MODE);
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = is_protected(a) || (a == OFF_CLOCK_FLAGS)
                || (a == OFF_IRQ_MASKING) || (a == OFF_WRITE_GUARD);
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old_v,
                                        input logic [15:0] wd,
                                        input logic [15:0] msk);
    merge = (old_v & ~msk) | (wd & msk);
  endfunction

  // ------------------------------------------------------------
  // lock pin synchroniser and edge detect
  // ------------------------------------------------------------
  logic lock_sync;
  logic lock_prev_ff;
  logic nxt_lock_prev;
  logic lock_rise;
  logic lock_fall;

  cuw_sync u_lock_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (clk_en),
    .async_in (pll_lock),
    .sync_out (lock_sync)
  );

  assign lock_rise = lock_sync & ~lock_prev_ff;
  assign lock_fall = ~lock_sync & lock_prev_ff;

  // ------------------------------------------------------------
  // apb access state
  // ------------------------------------------------------------
  cuw_state_t  state_ff;
  cuw_state_t  nxt_state;
  logic        acc_done;
  logic        wr_done;
  logic        rd_take;

  always_comb
  begin
    nxt_state = state_ff;
    if (clk_en)
    begin
      case (state_ff)
        CUW_IDLE:
        begin
          if (psel && !penable)
            nxt_state = CUW_ACCESS;
        end
        CUW_ACCESS:
        begin
          nxt_state = CUW_IDLE;
        end
        default:
        begin
          nxt_state = CUW_IDLE;
        end
      endcase
    end
  end

  // answer in the first access cycle
  assign pready   = clk_en && psel && penable && (state_ff == CUW_ACCESS);
  assign pslverr  = pready && !is_mapped(paddr);
  assign acc_done = pready && is_mapped(paddr);
  assign wr_done  = acc_done && pwrite;
  // a read is captured at the setup edge so that prdata comes from a flop
  assign rd_take  = clk_en && psel && !penable && !pwrite && (state_ff == CUW_IDLE)
                    && is_mapped(paddr);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  cuw_clk_cfg_t cfg_ff;
  cuw_clk_cfg_t nxt_cfg;
  logic [15:0]  mask_ff;
  logic [15:0]  nxt_mask;
  logic         unlock_ff;
  logic         nxt_unlock;
  logic         gain_flag_ff;
  logic         nxt_gain_flag;
  logic         lost_flag_ff;
  logic         nxt_lost_flag;
  logic [31:0]  rdata_ff;
  logic [31:0]  nxt_rdata;
  logic [15:0]  wd16;
  logic         prot_ok;

  assign wd16    = pwdata[15:0];
  assign prot_ok = wr_done && is_protected(paddr) && unlock_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_ff <= CUW_IDLE;
    else
      state_ff <= nxt_state;
  end

  // ------------------------------------------------------------
  // protected settings and write unlock
  // ------------------------------------------------------------
  // writes only land with pready, which already carries clk_en
  always_comb
  begin
    nxt_cfg    = cfg_ff;
    nxt_unlock = unlock_ff;
    if (prot_ok)
    begin
      if (paddr == OFF_PLL_SETUP)
        nxt_cfg.pll_setup = merge(cfg_ff.pll_setup, wd16, MASK_PLL_SETUP);
      else if (paddr == OFF_DIVIDER_SETUP)
        nxt_cfg.divider_setup = merge(cfg_ff.divider_setup, wd16, MASK_DIVIDER);
      else
        nxt_cfg.clock_mode_control = merge(cfg_ff.clock_mode_control, wd16,
                                           MASK_CLOCK_MODE);
      nxt_unlock = 1'b0;
    end
    else if (wr_done && paddr == OFF_WRITE_GUARD)
      nxt_unlock = wd16[BIT_UNLOCK];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_ff    <= '{RST_PLL_SETUP, RST_DIVIDER, RST_CLOCK_MODE};
      unlock_ff <= RST_WRITE_GUARD[BIT_UNLOCK];
    end
    else
    begin
      cfg_ff    <= nxt_cfg;
      unlock_ff <= nxt_unlock;
    end
  end

  // ------------------------------------------------------------
  // interrupt enables and stop permission
  // ------------------------------------------------------------
  always_comb
  begin
    nxt_mask = mask_ff;
    if (wr_done && paddr == OFF_IRQ_MASKING)
      nxt_mask = wd16 & MASK_IRQ_MASKING;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_ff <= RST_IRQ_MASKING;
    else
      mask_ff <= nxt_mask;
  end

  // ------------------------------------------------------------
  // lock flags
  // ------------------------------------------------------------
  always_comb
  begin
    nxt_gain_flag = gain_flag_ff;
    nxt_lost_flag = lost_flag_ff;
    nxt_lock_prev = lock_prev_ff;
    if (clk_en)
    begin
      nxt_lock_prev = lock_sync;
      // write one clears, a new edge in the same cycle wins
      if (wr_done && paddr == OFF_CLOCK_FLAGS && wd16[BIT_LOCK_GAIN])
        nxt_gain_flag = 1'b0;
      if (wr_done && paddr == OFF_CLOCK_FLAGS && wd16[BIT_LOCK_LOST])
        nxt_lost_flag = 1'b0;
      if (lock_rise)
        nxt_gain_flag = 1'b1;
      if (lock_fall)
        nxt_lost_flag = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gain_flag_ff <= 1'b0;
      lost_flag_ff <= 1'b0;
      lock_prev_ff <= 1'b0;
    end
    else
    begin
      gain_flag_ff <= nxt_gain_flag;
      lost_flag_ff <= nxt_lost_flag;
      lock_prev_ff <= nxt_lock_prev;
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  // loaded at the setup edge, it stands through the ready cycle and is zero after it
  always_comb
  begin
    nxt_rdata = rdata_ff;
    if (clk_en)
    begin
      nxt_rdata = 32'h0000_0000;
      if (rd_take)
      begin
        if (paddr == OFF_PLL_SETUP)
          nxt_rdata[15:0] = {lock_sync, cfg_ff.pll_setup[14:0]};
        else if (paddr == OFF_DIVIDER_SETUP)
          nxt_rdata[15:0] = cfg_ff.divider_setup;
        else if (paddr == OFF_CLOCK_FLAGS)
          nxt_rdata[15:0] = {gain_flag_ff, lost_flag_ff, 7'h00, clk_status};
        else if (paddr == OFF_CLOCK_MODE)
          nxt_rdata[15:0] = cfg_ff.clock_mode_control;
        else if (paddr == OFF_IRQ_MASKING)
          nxt_rdata[15:0] = mask_ff;
        else
          nxt_rdata[15:0] = {15'h0000, unlock_ff};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata_ff <= 32'h0000_0000;
    else
      rdata_ff <= nxt_rdata;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign prdata      = rdata_ff;
  assign clk_cfg     = cfg_ff;
  assign stop_enable = mask_ff[BIT_STOP_ENABLE];
  assign unit_irq    = (gain_flag_ff && mask_ff[BIT_LOCK_GAIN])
                       || (lost_flag_ff && mask_ff[BIT_LOCK_LOST]);

endmodule

`default_nettype wire

// File: testbench/cuw_top_checker.sv
// checker: port-level assertions for the clock unit mask and write guard
`timescale 1ns/100ps
`default_nettype none

module cuw_top_checker
  import cuw_pkg::*;
(
  // clock and reset
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         clk_en,
  // apb slave
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [7:0]   paddr,
  input wire logic [31:0]  pwdata,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic         pslverr,
  // clock unit side
  input wire logic         pll_lock,
  input wire logic [6:0]   clk_status,
  input wire cuw_clk_cfg_t clk_cfg,
  input wire logic         stop_enable,
  input wire logic         unit_irq
);
  // ------------------------------------------------------------
  // shadow of unlock bit and interrupt enables
  // ------------------------------------------------------------
  logic       wr;
  logic       rd;
  logic       prot;
  logic       unl_ff;
  logic       nxt_unl;
  logic [1:0] en_ff;
  logic [1:0] nxt_en;

  assign wr   = psel && penable && pwrite && pready;
  assign rd   = psel && penable && !pwrite && pready;
  assign prot = paddr == OFF_PLL_SETUP || paddr == OFF_DIVIDER_SETUP || paddr == OFF_CLOCK_MODE;

  always_comb
  begin
    nxt_unl = unl_ff;
    nxt_en  = en_ff;
    if (wr && paddr == OFF_WRITE_GUARD)
      nxt_unl = pwdata[0];
    else if (wr && prot)
      nxt_unl = 1'b0;
    if (wr && paddr == OFF_IRQ_MASKING)
      nxt_en = pwdata[15:14];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      unl_ff <= 1'b0;
      en_ff  <= 2'b00;
    end
    else
    begin
      unl_ff <= nxt_unl;
      en_ff  <= nxt_en;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_locked_hold: assert property (
    wr && prot && !unl_ff |=> $stable(clk_cfg)) else $error("locked write changed settings");
  a_divider_take: assert property (
    wr && paddr == OFF_DIVIDER_SETUP && unl_ff
    |=> clk_cfg.divider_setup == ($past(pwdata[15:0]) & MASK_DIVIDER))
    else $error("divider write lost");
  a_mode_take: assert property (
    wr && paddr == OFF_CLOCK_MODE && unl_ff
    |=> clk_cfg.clock_mode_control == ($past(pwdata[15:0]) & MASK_CLOCK_MODE))
    else $error("clock mode write lost");
  a_stop_follow: assert property (
    wr && paddr == OFF_IRQ_MASKING |=> stop_enable == $past(pwdata[0]))
    else $error("stop enable wrong");
  a_mask_read: assert property (
    rd && paddr == OFF_IRQ_MASKING |-> prdata == {16'h0, en_ff, 13'h0, stop_enable})
    else $error("mask read wrong");
  a_guard_read: assert property (
    rd && paddr == OFF_WRITE_GUARD |-> prdata == {31'h0, unl_ff}) else $error("guard read wrong");
  a_irq_off: assert property (
    en_ff == 2'b00 |-> !unit_irq) else $error("interrupt while disabled");
  a_irq_read: assert property (
    rd && paddr == OFF_CLOCK_FLAGS
    |-> $past(unit_irq) == ((prdata[15] && en_ff[1]) || (prdata[14] && en_ff[0])))
    else $error("interrupt disagrees with flags");

endmodule

bind cuw_top cuw_top_checker i_cuw_top_checker (.pclk, .presetn, .clk_en, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pll_lock, .clk_status, .clk_cfg,
  .stop_enable, .unit_irq);

`default_nettype wire

// File: testbench/cuw_top_tb.sv
// testbench: apb stimulus and read scoreboard for the clock unit mask and write guard
`timescale 1ns/100ps
`default_nettype none

module cuw_top_tb
  import cuw_pkg::*;
;
  typedef struct {string nm; logic [31:0] d; logic e;} cuw_note_t;
  localparam logic [7:0]  PA[3] = '{OFF_PLL_SETUP, OFF_DIVIDER_SETUP, OFF_CLOCK_MODE};
  localparam logic [31:0] PM[3] = '{32'(MASK_PLL_SETUP), 32'(MASK_DIVIDER),
                                    32'(MASK_CLOCK_MODE)};
  logic         pclk = 1'b0;
  logic         presetn = 1'b0;
  logic         clk_en = 1'b1;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic         pll_lock = 1'b0;
  logic [7:0]   paddr = 8'h00;
  logic [31:0]  pwdata = 32'h0;
  logic [6:0]   clk_status = 7'h00;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         stop_enable;
  logic         unit_irq;
  cuw_clk_cfg_t clk_cfg;
  cuw_note_t    notes[$];
  cuw_note_t    nt;
  int           n_mismatch = 0;
  int           checks = 0;

  always #5 pclk = ~pclk;

  cuw_top i_cuw_top (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pll_lock, .clk_status, .clk_cfg, .stop_enable, .unit_irq);

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    if (n_mismatch == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      n_mismatch++;
      conclude();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] d,
                    input logic e = 1'b0);
    notes.push_back('{nm, d, e});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic irq(input logic exp);
    @(negedge pclk);
    check("unit_irq", {31'h0, unit_irq}, {31'h0, exp});
  endtask

  // ------------------------------------------------------------
  // read scoreboard
  // ------------------------------------------------------------
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      nt = notes.pop_front();
      check(nt.nm, prdata, nt.d);
      check({nt.nm, " pslverr"}, {31'h0, pslverr}, {31'h0, nt.e});
    end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    logic [31:0] v;
    logic [31:0] s;
    void'($urandom(38002));
    repeat (6) @(posedge pclk);
    s = {25'h0, 7'($urandom)};
    presetn    <= 1'b1;
    clk_status <= s[6:0];
    for (int i = 0; i < 6; i++)
      rd("reset value", 8'(4 * i), (i == 2) ? s : 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      v = $urandom;
      apb(1'b1, PA[i], v);
      rd("locked write", PA[i], 32'h0);
      rd("write_guard", OFF_WRITE_GUARD, 32'h0);
      apb(1'b1, OFF_WRITE_GUARD, 32'hffff_ffff);
      rd("write_guard", OFF_WRITE_GUARD, 32'h1);
      apb(1'b1, PA[i], v);
      rd("unlocked write", PA[i], v & PM[i]);
      rd("write_guard", OFF_WRITE_GUARD, 32'h0);
      apb(1'b1, PA[i], ~v);
      rd("relocked write", PA[i], v & PM[i]);
    end
    apb(1'b1, OFF_WRITE_GUARD, 32'h1);
    apb(1'b1, OFF_WRITE_GUARD, 32'h0);
    rd("write_guard", OFF_WRITE_GUARD, 32'h0);
    apb(1'b1, OFF_IRQ_MASKING, 32'hffff_ffff);
    rd("irq_masking", OFF_IRQ_MASKING, 32'h0000_c001);
    @(negedge pclk);
    check("stop_enable", {31'h0, stop_enable}, 32'h1);
    apb(1'b1, OFF_IRQ_MASKING, 32'h0);
    @(negedge pclk);
    check("stop_enable", {31'h0, stop_enable}, 32'h0);
    @(posedge pclk);
    pll_lock <= 1'b1;
    repeat (5) @(posedge pclk);
    irq(1'b0);
    rd("clock_flags", OFF_CLOCK_FLAGS, s | 32'h8000);
    apb(1'b1, OFF_IRQ_MASKING, 32'h8000);
    irq(1'b1);
    apb(1'b1, OFF_CLOCK_FLAGS, 32'h4000);
    rd("clock_flags", OFF_CLOCK_FLAGS, s | 32'h8000);
    apb(1'b1, OFF_CLOCK_FLAGS, 32'h8000);
    rd("clock_flags", OFF_CLOCK_FLAGS, s);
    irq(1'b0);
    @(posedge pclk);
    pll_lock <= 1'b0;
    repeat (5) @(posedge pclk);
    irq(1'b0);
    rd("clock_flags", OFF_CLOCK_FLAGS, s | 32'h4000);
    apb(1'b1, OFF_IRQ_MASKING, 32'h4000);
    irq(1'b1);
    apb(1'b1, OFF_CLOCK_FLAGS, 32'h4000);
    rd("clock_flags", OFF_CLOCK_FLAGS, s);
    irq(1'b0);
    rd("unmapped", 8'h18, 32'h0, 1'b1);
    // a lock edge while clk_en is low must wait until the enable returns
    apb(1'b1, OFF_IRQ_MASKING, 32'h0000_c000);
    @(posedge pclk);
    clk_en   <= 1'b0;
    pll_lock <= 1'b1;
    repeat (6) @(posedge pclk);
    irq(1'b0);
    @(posedge pclk);
    clk_en <= 1'b1;
    repeat (5) @(posedge pclk);
    irq(1'b1);
    rd("clock_flags", OFF_CLOCK_FLAGS, s | 32'h8000);
    apb(1'b1, OFF_CLOCK_FLAGS, 32'h8000);
    irq(1'b0);
    repeat (3) @(posedge pclk);
    conclude();
  end

endmodule

`default_nettype wire
